/* inc/mct_pkg.sv */
// Register map, field layout and sizing constants of the match/capture timer
package mct_pkg;

	localparam int unsigned DEF_CNT_W = 32;
	localparam int unsigned NARROW_CNT_W = 16;
	localparam int unsigned WB_DAT_W = 32;
	localparam int unsigned WB_ADR_W = 8;
	localparam int unsigned WB_SEL_W = 4;
	localparam int unsigned NUM_MATCH = 4;
	localparam int unsigned NUM_OUT = 2;

	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_PRESCALE = 8'h04;
	localparam logic [7:0] ADR_PRESCALE_COUNT = 8'h08;
	localparam logic [7:0] ADR_COUNT = 8'h0C;
	localparam logic [7:0] ADR_MATCH0 = 8'h10;
	localparam logic [7:0] ADR_MATCH_CTRL = 8'h20;
	localparam logic [7:0] ADR_OUT_CTRL = 8'h24;
	localparam logic [7:0] ADR_CAPTURE = 8'h28;
	localparam logic [7:0] ADR_IRQ_STATUS = 8'h2C;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h30;
	localparam logic [7:0] ADR_OUT_STATE = 8'h34;

	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam int unsigned CTRL_CLEAR_BIT = 1;
	localparam int unsigned CTRL_PWM0_BIT = 2;
	localparam int unsigned CTRL_CAP_RISE_BIT = 4;
	localparam int unsigned CTRL_CAP_FALL_BIT = 5;
	localparam int unsigned CTRL_CAP_IRQ_BIT = 6;
	localparam int unsigned CTRL_W = 7;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

	localparam int unsigned MC_IRQ_OFS = 0;
	localparam int unsigned MC_RESET_OFS = 1;
	localparam int unsigned MC_STOP_OFS = 2;
	localparam int unsigned MC_STRIDE = 3;
	localparam int unsigned MC_W = 12;
	localparam logic [MC_W-1:0] MC_RESET = 12'h000;

	localparam int unsigned OUT_ACT_W = 2;
	localparam int unsigned OUT_CTRL_W = 4;
	localparam logic [OUT_CTRL_W-1:0] OUT_CTRL_RESET = 4'h0;

	localparam int unsigned IRQ_CAP_BIT = 4;
	localparam int unsigned IRQ_W = 5;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

	typedef enum logic [1:0] {
		ACT_NONE = 2'h0,
		ACT_LOW = 2'h1,
		ACT_HIGH = 2'h2,
		ACT_TOGGLE = 2'h3
	} mct_action_type;

endpackage

/* inc/mct_if.sv */
// Links the timer core with its prescaler and capture units
`timescale 1ns/1ns
interface mct_if #(
	parameter int unsigned W = 32
);
	logic run;
	logic clear;
	logic [W-1:0] terminal;
	logic tick;
	logic [W-1:0] prescale_count;
	logic cap_rise_en;
	logic cap_fall_en;
	logic [W-1:0] count;
	logic cap_event;
	logic [W-1:0] cap_value;

	modport pre (
		input run,
		input clear,
		input terminal,
		output tick,
		output prescale_count
	);

	modport cap (
		input cap_rise_en,
		input cap_fall_en,
		input count,
		output cap_event,
		output cap_value
	);
endinterface

/* src/mct_prescale.sv */
// Prescaler that divides the peripheral clock into count-enable pulses
`timescale 1ns/1ns
module mct_prescale #(
	parameter int unsigned W = 32
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	mct_if.pre bus
);
	logic [W-1:0] pc;

	assign bus.prescale_count = pc;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pc <= '0;
			bus.tick <= 1'b0;
		end else if (bus.clear || !bus.run) begin
			pc <= '0;
			bus.tick <= 1'b0;
		end else if (pc == bus.terminal) begin
			pc <= '0;
			bus.tick <= 1'b1;
		end else begin
			pc <= pc + 1'b1;
			bus.tick <= 1'b0;
		end
	end
endmodule // mct_prescale

/* src/mct_capture.sv */
// Capture pin synchroniser, edge detector and count latch
`timescale 1ns/1ns
module mct_capture #(
	parameter int unsigned W = 32
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_capture,
	mct_if.cap bus
);
	logic sync1;
	logic sync2;
	logic last;
	logic rise;
	logic fall;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			last <= 1'b0;
		end else begin
			sync1 <= i_capture;
			sync2 <= sync1;
			last <= sync2;
		end
	end

	assign rise = sync2 & ~last;
	assign fall = ~sync2 & last;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bus.cap_event <= 1'b0;
			bus.cap_value <= '0;
		end else begin
			bus.cap_event <= (rise & bus.cap_rise_en) | (fall & bus.cap_fall_en);
			if ((rise & bus.cap_rise_en) | (fall & bus.cap_fall_en)) begin
				bus.cap_value <= bus.count;
			end
		end
	end
endmodule // mct_capture

/* src/mct_timer.sv */
// Match/capture counter-timer with Wishbone register slave
`timescale 1ns/1ns
module mct_timer import mct_pkg::*; #(
	parameter int unsigned CNT_W = DEF_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [WB_ADR_W-1:0] i_wb_adr,
	input wire logic [WB_SEL_W-1:0] i_wb_sel,
	input wire logic [WB_DAT_W-1:0] i_wb_dat,
	output logic [WB_DAT_W-1:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_capture,
	output logic [NUM_OUT-1:0] o_match,
	output logic o_irq
);

	function automatic logic [WB_DAT_W-1:0] zext(input logic [CNT_W-1:0] v);
		logic [WB_DAT_W-1:0] r;
		r = '0;
		r[CNT_W-1:0] = v;
		return r;
	endfunction

	// Byte lanes not selected keep their old contents
	function automatic logic [WB_DAT_W-1:0] merge(input logic [WB_DAT_W-1:0] old,
		input logic [WB_DAT_W-1:0] data, input logic [WB_SEL_W-1:0] sel);
		logic [WB_DAT_W-1:0] r;
		r = old;
		for (int b = 0; b < WB_SEL_W; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return r;
	endfunction

	logic [CTRL_W-1:0] ctrl;
	logic [CNT_W-1:0] prescale;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] match [NUM_MATCH];
	logic [MC_W-1:0] match_ctrl;
	logic [OUT_CTRL_W-1:0] out_ctrl;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [CNT_W-1:0] capture;

	logic req;
	logic wr;
	logic step;
	logic [NUM_MATCH-1:0] hit;
	logic [NUM_MATCH-1:0] hit_irq;
	logic any_reset;
	logic any_stop;
	logic [WB_DAT_W-1:0] next_rdata;
	logic [IRQ_W-1:0] next_irq_status;

	mct_if #(.W(CNT_W)) link ();

	assign link.run = ctrl[CTRL_RUN_BIT];
	assign link.clear = ctrl[CTRL_CLEAR_BIT];
	assign link.terminal = prescale;
	assign link.cap_rise_en = ctrl[CTRL_CAP_RISE_BIT];
	assign link.cap_fall_en = ctrl[CTRL_CAP_FALL_BIT];
	assign link.count = count;

	mct_prescale #(.W(CNT_W)) u_prescale (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.bus(link)
	);

	mct_capture #(.W(CNT_W)) u_capture (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_capture(i_capture),
		.bus(link)
	);

	// Classic Wishbone: one request, ack one cycle later
	assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign wr = req & i_wb_we;

	// Run may have been cleared by a stop while a tick was in flight
	assign step = link.tick & ctrl[CTRL_RUN_BIT] & ~ctrl[CTRL_CLEAR_BIT];

	always_comb begin
		for (int i = 0; i < NUM_MATCH; i++) begin
			hit[i] = step && (count == match[i]);
			hit_irq[i] = hit[i] & match_ctrl[i*MC_STRIDE + MC_IRQ_OFS];
		end
	end

	always_comb begin
		any_reset = 1'b0;
		any_stop = 1'b0;
		for (int i = 0; i < NUM_MATCH; i++) begin
			any_reset = any_reset | (hit[i] & match_ctrl[i*MC_STRIDE + MC_RESET_OFS]);
			any_stop = any_stop | (hit[i] & match_ctrl[i*MC_STRIDE + MC_STOP_OFS]);
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= req;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl <= CTRL_RESET;
		end else begin
			if (wr && i_wb_adr == ADR_CTRL) begin
				ctrl <= CTRL_W'(merge(WB_DAT_W'(ctrl), i_wb_dat, i_wb_sel));
			end
			if (any_stop) begin
				ctrl[CTRL_RUN_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prescale <= '0;
		end else if (wr && i_wb_adr == ADR_PRESCALE) begin
			prescale <= CNT_W'(merge(zext(prescale), i_wb_dat, i_wb_sel));
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < NUM_MATCH; i++) begin
				match[i] <= '0;
			end
		end else if (wr && i_wb_adr[7:4] == ADR_MATCH0[7:4]) begin
			match[i_wb_adr[3:2]] <= CNT_W'(merge(zext(match[i_wb_adr[3:2]]), i_wb_dat, i_wb_sel));
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			match_ctrl <= MC_RESET;
			out_ctrl <= OUT_CTRL_RESET;
			irq_mask <= IRQ_RESET;
		end else if (wr) begin
			if (i_wb_adr == ADR_MATCH_CTRL) begin
				match_ctrl <= MC_W'(merge(WB_DAT_W'(match_ctrl), i_wb_dat, i_wb_sel));
			end
			if (i_wb_adr == ADR_OUT_CTRL) begin
				out_ctrl <= OUT_CTRL_W'(merge(WB_DAT_W'(out_ctrl), i_wb_dat, i_wb_sel));
			end
			if (i_wb_adr == ADR_IRQ_MASK) begin
				irq_mask <= IRQ_W'(merge(WB_DAT_W'(irq_mask), i_wb_dat, i_wb_sel));
			end
		end
	end

	// Software write beats both clear and counting in the same cycle
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count <= '0;
		end else if (wr && i_wb_adr == ADR_COUNT) begin
			count <= CNT_W'(merge(zext(count), i_wb_dat, i_wb_sel));
		end else if (ctrl[CTRL_CLEAR_BIT]) begin
			count <= '0;
		end else if (step) begin
			if (any_reset) begin
				count <= '0;
			end else begin
				count <= count + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			capture <= '0;
		end else if (link.cap_event) begin
			capture <= link.cap_value;
		end
	end

	// Pulse-width mode compares every cycle, so a new match takes effect at once
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_match <= '0;
		end else begin
			for (int i = 0; i < NUM_OUT; i++) begin
				if (ctrl[CTRL_PWM0_BIT + i]) begin
					o_match[i] <= (count >= match[i]);
				end else if (hit[i]) begin
					unique case (mct_action_type'(out_ctrl[i*OUT_ACT_W +: OUT_ACT_W]))
						ACT_NONE: o_match[i] <= o_match[i];
						ACT_LOW: o_match[i] <= 1'b0;
						ACT_HIGH: o_match[i] <= 1'b1;
						ACT_TOGGLE: o_match[i] <= ~o_match[i];
					endcase
				end
			end
		end
	end

	// A new event in the clearing cycle survives the write-one-to-clear
	always_comb begin
		next_irq_status = irq_status;
		if (wr && i_wb_adr == ADR_IRQ_STATUS) begin
			next_irq_status = irq_status & ~(IRQ_W'(i_wb_dat & {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
				{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}}));
		end
		next_irq_status[NUM_MATCH-1:0] = next_irq_status[NUM_MATCH-1:0] | hit_irq;
		if (link.cap_event && ctrl[CTRL_CAP_IRQ_BIT]) begin
			next_irq_status[IRQ_CAP_BIT] = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_status <= IRQ_RESET;
			o_irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			o_irq <= |(next_irq_status & irq_mask);
		end
	end

	always_comb begin
		next_rdata = '0;
		if (i_wb_adr[7:4] == ADR_MATCH0[7:4]) begin
			next_rdata = zext(match[i_wb_adr[3:2]]);
		end else begin
			unique case (i_wb_adr)
				ADR_CTRL: next_rdata = WB_DAT_W'(ctrl);
				ADR_PRESCALE: next_rdata = zext(prescale);
				ADR_PRESCALE_COUNT: next_rdata = zext(link.prescale_count);
				ADR_COUNT: next_rdata = zext(count);
				ADR_MATCH_CTRL: next_rdata = WB_DAT_W'(match_ctrl);
				ADR_OUT_CTRL: next_rdata = WB_DAT_W'(out_ctrl);
				ADR_CAPTURE: next_rdata = zext(capture);
				ADR_IRQ_STATUS: next_rdata = WB_DAT_W'(irq_status);
				ADR_IRQ_MASK: next_rdata = WB_DAT_W'(irq_mask);
				ADR_OUT_STATE: next_rdata = WB_DAT_W'(o_match);
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_wb_dat <= '0;
		end else if (req) begin
			o_wb_dat <= i_wb_we ? '0 : next_rdata;
		end
	end

endmodule // mct_timer

/* tb/mct_timer_chk.sv */
// Bus and interrupt assertions for the match/capture timer
`timescale 1ns/1ns
module mct_timer_chk import mct_pkg::*; #(
	parameter int unsigned CNT_W = DEF_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [WB_ADR_W-1:0] i_wb_adr,
	input wire logic [WB_SEL_W-1:0] i_wb_sel,
	input wire logic [WB_DAT_W-1:0] i_wb_dat,
	input wire logic [WB_DAT_W-1:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic i_capture,
	input wire logic [NUM_OUT-1:0] o_match,
	input wire logic o_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence s_rd(a);
		s_req ##0 !i_wb_we && i_wb_adr == a ##1 o_wb_ack;
	endsequence
	ack_follows_a: assert property (s_req |=> o_wb_ack) else $error("ack missing");
	ack_single_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	ack_cause_a: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb)) else $error("stray ack");
	write_zero_a: assert property (s_req ##0 i_wb_we ##1 o_wb_ack |-> o_wb_dat == '0) else $error("write data");
	hole_zero_a: assert property (s_rd(8'h40) |-> o_wb_dat == '0) else $error("hole read");
	ctrl_bits_a: assert property (s_rd(ADR_CTRL) |-> o_wb_dat[31:CTRL_W] == '0) else $error("ctrl bits");
	count_width_a: assert property ((s_rd(ADR_COUNT) or s_rd(ADR_CAPTURE) or s_rd(ADR_PRESCALE))
		|-> (o_wb_dat >> CNT_W) == '0) else $error("count width");
	mask_off_a: assert property (s_req ##0 i_wb_we && i_wb_adr == ADR_IRQ_MASK && i_wb_sel[0]
		&& i_wb_dat[IRQ_W-1:0] == '0 ##1 o_wb_ack |=> !o_irq) else $error("irq unmasked");
	reset_idle_a: assert property ($rose(i_reset_n) |-> !o_irq && o_match == '0 && !o_wb_ack) else $error("reset");
endmodule // mct_timer_chk

bind mct_timer mct_timer_chk #(.CNT_W(CNT_W)) u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.i_capture(i_capture), .o_match(o_match), .o_irq(o_irq));

/* tb/mct_pin_model.sv */
// Pin side: drives the capture pin, totals high cycles of both match outputs
`timescale 1ns/1ns
module mct_pin_model import mct_pkg::*; (
	input wire logic i_clk,
	input wire logic i_level,
	input wire logic i_clr,
	input wire logic [NUM_OUT-1:0] i_match,
	output logic o_capture,
	output logic [7:0] o_high,
	output logic [7:0] o_high1
);
	always_ff @(posedge i_clk) begin
		o_capture <= i_level;
	end
	always_ff @(posedge i_clk) begin
		if (i_clr) begin
			o_high <= 8'h00;
		end else begin
			o_high <= o_high + {7'h00, i_match[0]};
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_clr) begin
			o_high1 <= 8'h00;
		end else begin
			o_high1 <= o_high1 + {7'h00, i_match[1]};
		end
	end
endmodule // mct_pin_model

/* tb/match_capture_timer_tb_top.sv */
// Self-checking bench for the match/capture timer
`timescale 1ns/1ns
module match_capture_timer_tb_top import mct_pkg::*;;
	localparam int P = 3;
	logic i_clk, i_reset_n, cyc, stb, we, lvl, pclr, ack, irq, cap;
	logic [7:0] adr, high, high1;
	logic [31:0] dat, q, c, rdat, rdat_w, qw;
	logic [NUM_OUT-1:0] mo;
	int n_mismatch = 0;
	int n_compared = 0;
	int k;
	logic [7:0] ra[10] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h30, 8'h28, 8'h40};
	logic [31:0] rw[10] = '{32'hFFFF1234, 32'h12345678, 32'h0000ABCD, 32'hFFFF0001, 32'h00008000,
		32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
	logic [31:0] rx[10] = '{32'h1234, 32'h5678, 32'hABCD, 32'h1, 32'h8000, 32'hFFF, 32'hF, 32'h1F, 32'h0, 32'h0};
	logic [1:0] ac[3] = '{ACT_HIGH, ACT_LOW, ACT_NONE};
	logic ax[3] = '{1'b1, 1'b0, 1'b0};

	mct_timer #(.CNT_W(NARROW_CNT_W)) uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_capture(cap), .o_match(mo), .o_irq(irq));
	// Wide variant shares the bus; only its read data is looked at
	mct_timer #(.CNT_W(DEF_CNT_W)) uut_wide (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(rdat_w),
		.o_wb_ack(), .i_capture(cap), .o_match(), .o_irq());
	mct_pin_model pins (.i_clk(i_clk), .i_level(lvl), .i_clr(pclr), .i_match(mo), .o_capture(cap), .o_high(high),
		.o_high1(high1));

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	task automatic give_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			n_mismatch++;
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge i_clk);
			t++;
		end while (ack !== 1'b1 && t < 50);
		q = rdat;
		qw = rdat_w;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge i_clk);
		if (t >= 50) begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	task automatic edge0(output int n);
		logic v;
		v = mo[0];
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (mo[0] === v && n < 100);
		if (n >= 100) begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	initial begin
		i_reset_n = 1'b0;
		{cyc, stb, we, lvl, pclr, adr, dat} = '0;
		repeat (6) @(posedge i_clk);
		i_reset_n <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			wb(1'b0, ra[i], 32'h0);
			chk("reset value", 32'h0, q);
			wb(1'b1, ra[i], rw[i]);
			wb(1'b0, ra[i], 32'h0);
			chk("readback", rx[i], q);
		end
		i_reset_n <= 1'b0;
		repeat (6) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		chk("idle outputs", 32'h0, {mo, irq});
		wb(1'b0, ADR_MATCH0, 32'h0);
		chk("match0 cleared", 32'h0, q);
		wb(1'b1, ADR_PRESCALE, 32'hFFFF1234);
		wb(1'b0, ADR_PRESCALE, 32'h0);
		chk("wide prescale", 32'hFFFF1234, qw);
		chk("narrow prescale", 32'h1234, q);
		// Run spans 43 clocks between the two writes
		wb(1'b1, ADR_PRESCALE, P);
		wb(1'b1, ADR_CTRL, 32'h1);
		repeat (40) @(posedge i_clk);
		wb(1'b1, ADR_CTRL, 32'h0);
		wb(1'b0, ADR_COUNT, 32'h0);
		chk("count rate", 32'h1, q == 43 / (P + 1) || q == 43 / (P + 1) - 1);
		wb(1'b1, ADR_PRESCALE, 32'h0);
		wb(1'b1, ADR_COUNT, 32'h0);
		wb(1'b1, ADR_MATCH0, 32'h9);
		wb(1'b1, ADR_MATCH_CTRL, 32'h3);
		wb(1'b1, ADR_OUT_CTRL, ACT_TOGGLE);
		wb(1'b1, ADR_IRQ_MASK, 32'h1);
		wb(1'b1, ADR_CTRL, 32'h1);
		edge0(k);
		edge0(k);
		chk("toggle period", 32'hA, k);
		chk("irq", 32'h1, irq);
		wb(1'b0, ADR_IRQ_STATUS, 32'h0);
		chk("status", 32'h1, q);
		wb(1'b1, ADR_IRQ_MASK, 32'h0);
		chk("irq masked", 32'h0, irq);
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, ADR_OUT_CTRL, ac[i]);
			repeat (25) @(posedge i_clk);
			chk("out action", ax[i], mo[0]);
			wb(1'b0, ADR_OUT_STATE, 32'h0);
			chk("out state", {31'h0, ax[i]}, q);
		end
		wb(1'b1, ADR_CTRL, 32'h0);
		wb(1'b1, ADR_IRQ_STATUS, 32'h1F);
		wb(1'b0, ADR_IRQ_STATUS, 32'h0);
		chk("status cleared", 32'h0, q);
		wb(1'b1, ADR_COUNT, 32'h0);
		wb(1'b1, ADR_MATCH0 + 8'h04, 32'h8);
		wb(1'b1, ADR_MATCH0 + 8'h08, 32'h3);
		wb(1'b1, ADR_MATCH_CTRL, 32'h60);
		wb(1'b1, ADR_CTRL, 32'h1);
		repeat (30) @(posedge i_clk);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("run cleared", 32'h0, q);
		wb(1'b0, ADR_COUNT, 32'h0);
		c = q;
		wb(1'b0, ADR_COUNT, 32'h0);
		chk("count held", c, q);
		chk("ran past match2", 32'h1, q > 3);
		wb(1'b0, ADR_IRQ_STATUS, 32'h0);
		chk("match2 flag", 32'h4, q);
		wb(1'b1, ADR_COUNT, 32'h0);
		wb(1'b1, ADR_MATCH0, 32'h5);
		wb(1'b1, ADR_MATCH0 + 8'h0C, 32'h13);
		wb(1'b1, ADR_MATCH_CTRL, 32'h400);
		wb(1'b1, ADR_CTRL, 32'hD);
		repeat (50) @(posedge i_clk);
		pclr <= 1'b1;
		@(posedge i_clk);
		pclr <= 1'b0;
		// Two whole periods, so the phase does not matter
		repeat (41) @(posedge i_clk);
		chk("pwm high", 32'h1E, high);
		chk("pwm1 high", 32'h18, high1);
		wb(1'b1, ADR_MATCH_CTRL, 32'h0);
		wb(1'b1, ADR_IRQ_STATUS, 32'h1F);
		wb(1'b1, ADR_IRQ_MASK, 32'h10);
		wb(1'b1, ADR_CTRL, 32'h51);
		lvl <= 1'b1;
		repeat (10) @(posedge i_clk);
		chk("capture irq", 32'h1, irq);
		wb(1'b0, ADR_CAPTURE, 32'h0);
		c = q;
		wb(1'b0, ADR_COUNT, 32'h0);
		chk("capture value", 32'h1, c != 0 && c < q);
		wb(1'b1, ADR_IRQ_STATUS, 32'h10);
		lvl <= 1'b0;
		repeat (10) @(posedge i_clk);
		wb(1'b0, ADR_IRQ_STATUS, 32'h0);
		chk("falling ignored", 32'h0, q);
		wb(1'b1, ADR_CTRL, 32'h61);
		lvl <= 1'b1;
		repeat (10) @(posedge i_clk);
		wb(1'b0, ADR_IRQ_STATUS, 32'h0);
		chk("rising ignored", 32'h0, q);
		lvl <= 1'b0;
		repeat (10) @(posedge i_clk);
		wb(1'b0, ADR_IRQ_STATUS, 32'h0);
		chk("falling capture", 32'h10, q);
		wb(1'b1, ADR_CTRL, 32'h3);
		repeat (5) @(posedge i_clk);
		wb(1'b0, ADR_COUNT, 32'h0);
		chk("count cleared", 32'h0, q);
		give_verdict();
	end
endmodule // match_capture_timer_tb_top
